// ---- obcd_checker.sv ----
// Purpose: Port-level assertions for the configuration byte decoder
// Assumes: Single clock domain, asynchronous active-low reset
// Notes:   Attached to every decoder instance by bind
`timescale 1ns/100ps
module obcd_checker #(parameter NUM_PORTS = 6)
(
  input wire                   i_core_clk,
  input wire                   i_rst_n,
  input wire                   i_prog_mode,
  input wire                   i_prog_rd,
  input wire [7:0]             o_prog_rdata,
  input wire                   o_prog_busy,
  input wire                   o_mem_wipe,
  input wire                   i_mem_wipe_done,
  input wire                   i_dog_active,
  input wire                   i_halt_enter,
  input wire                   o_halt_reset,
  input wire                   o_halt_triggers_dog_reset,
  input wire                   o_dog_enable_by_software,
  input wire                   o_dog_hw_enable,
  input wire                   o_readout_protect_n,
  input wire                   o_block_readout,
  input wire                   o_block_flash_write,
  input wire                   o_package_select,
  input wire [NUM_PORTS*8-1:0] o_pad_unbonded,
  input wire                   o_reset_phase_length_sel,
  input wire [12:0]            o_reset_cycles,
  input wire [1:0]             o_clock_source_type,
  input wire                   o_clk_int_rc,
  input wire                   o_clk_external,
  input wire                   o_clk_resonator,
  input wire                   o_clk_reserved
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  a_halt_gives_reset:
    assert property (i_halt_enter && o_halt_triggers_dog_reset &&
      (i_dog_active || o_dog_hw_enable) |=> o_halt_reset)
    else $error("halt reset missing");
  a_halt_reset_cause:
    assert property (o_halt_reset |->
      $past(i_halt_enter && o_halt_triggers_dog_reset))
    else $error("halt reset without cause");
  a_dog_type_sel:
    assert property (o_dog_hw_enable == !o_dog_enable_by_software)
    else $error("dog type wrong");
  a_protect_blocks:
    assert property (o_block_readout == !o_readout_protect_n)
    else $error("readout block wrong");
  a_protect_flash_wr:
    assert property (o_block_flash_write == !o_readout_protect_n)
    else $error("flash write block wrong");
  a_clk_src_rest:
    assert property (o_clk_resonator == (o_clock_source_type == 2'h0) &&
      o_clk_reserved == (o_clock_source_type == 2'h1))
    else $error("clock decode rest wrong");
  a_pads_per_pkg:
    assert property ((o_pad_unbonded == '0) == o_package_select)
    else $error("pad map wrong");
  a_reset_len_val:
    assert property (o_reset_cycles ==
      (o_reset_phase_length_sel ? 13'h0100 : 13'h1000))
    else $error("reset length wrong");
  a_clk_src_decode:
    assert property (o_clk_int_rc == (o_clock_source_type == 2'h2) &&
      o_clk_external == (o_clock_source_type == 2'h3))
    else $error("clock decode wrong");
  a_settings_held:
    assert property ($past(i_rst_n) |-> $stable({o_halt_triggers_dog_reset,
      o_readout_protect_n, o_package_select, o_clock_source_type}))
    else $error("settings moved");
  a_wipe_ends_done:
    assert property (o_mem_wipe && i_mem_wipe_done |=> !o_mem_wipe)
    else $error("wipe not ended");
  a_read_refused:
    assert property (!i_prog_mode && i_prog_rd |=> o_prog_rdata == 8'h00)
    else $error("read outside mode");
endmodule // obcd_checker

bind obcd_decoder obcd_checker #(.NUM_PORTS(NUM_PORTS)) u_chk (.*);

// ---- obcd_decoder.v ----
// Purpose: Holds the two configuration bytes and decodes them into
//          watchdog, protection, package, reset and clock settings
// Assumes: One clock, programming port used only in programming mode
// Notes:   Settings are captured in reset and held until next reset
//
// How it works
// - Halt with active dog gives reset
// - Dog type: hardware always-on or software
// - Read protect blocks readout and flash writes
// - Erasing protected bytes first wipes user memory
// - Package bit picks 48/44 or 32/34 bonding
// - Unbonded pads reset to input pull-up
// - Reset length bit gives 4096 or 256
// - Two-bit field selects main clock source
// - Internal RC nominal 3.5 MHz, CPU 1.75
// - Bytes reachable only in programming mode
// - Unprogrammed bytes read as FFh
// - Shipped bytes select internal RC clock
// - Masked ROM parts hard-wire the bytes
//
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
`include "obcd_regs.vh"

module obcd_decoder #(
  parameter       IS_ROM      = 0,
  parameter [7:0] ROM_BYTE0   = `OBCD_SHIP_BYTE0,
  parameter [7:0] ROM_BYTE1   = `OBCD_SHIP_BYTE1,
  parameter       NUM_PORTS   = 6,
  parameter       ERASE_CYC   = 16
)
(
  // Clock and reset
  input  wire                   i_core_clk,
  input  wire                   i_rst_n,
  // Programming port, active only in programming mode
  input  wire                   i_prog_mode,
  input  wire [1:0]             i_prog_cmd,
  input  wire                   i_prog_sel,
  input  wire [7:0]             i_prog_wdata,
  input  wire                   i_prog_rd,
  output reg  [7:0]             o_prog_rdata,
  output wire                   o_prog_busy,
  // User memory wipe request
  output reg                    o_mem_wipe,
  input  wire                   i_mem_wipe_done,
  // Watchdog and halt
  input  wire                   i_dog_active,
  input  wire                   i_halt_enter,
  output reg                    o_halt_reset,
  output wire                   o_halt_triggers_dog_reset,
  output wire                   o_dog_enable_by_software,
  output wire                   o_dog_hw_enable,
  // Protection
  output wire                   o_readout_protect_n,
  output wire                   o_block_readout,
  output wire                   o_block_flash_write,
  // Package and pads
  output wire                   o_package_select,
  output wire [NUM_PORTS*8-1:0] o_pad_unbonded,
  // Reset sequencer and clock
  output wire                   o_reset_phase_length_sel,
  output wire [12:0]            o_reset_cycles,
  output wire [1:0]             o_clock_source_type,
  output wire                   o_clk_resonator,
  output wire                   o_clk_int_rc,
  output wire                   o_clk_external,
  output wire                   o_clk_reserved
);

  ////////////////////////////////////////////////////////////////////////
  // Non-volatile store and latched copy

  localparam ST_IDLE  = 2'h0;
  localparam ST_WIPE  = 2'h1;
  localparam ST_ERASE = 2'h2;

  reg [7:0] nv0_q;
  reg [7:0] nv1_q;
  reg [7:0] cfg0_q;
  reg [7:0] cfg1_q;
  reg [1:0] state_q;
  reg [7:0] cnt_q;
  reg       sel_q;

  wire [7:0] src0 = (IS_ROM != 0) ? ROM_BYTE0 : nv0_q;
  wire [7:0] src1 = (IS_ROM != 0) ? ROM_BYTE1 : nv1_q;
  wire       prot_now = ~nv0_q[`OBCD_B0_RDPROT_N_BIT];
  wire       port_ok  = i_prog_mode & (IS_ROM == 0) & (state_q == ST_IDLE);

  assign o_prog_busy = (state_q != ST_IDLE);

  always @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_prog_rdata <= 8'h00;
    else if (i_prog_rd & port_ok)
      o_prog_rdata <= i_prog_sel ? src1 : src0;
    else
      o_prog_rdata <= 8'h00;
  end

  always @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_q    <= ST_IDLE;
      cnt_q      <= 8'h00;
      sel_q      <= 1'b0;
      o_mem_wipe <= 1'b0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (port_ok && i_prog_cmd == `OBCD_CMD_ERASE)
          begin
            sel_q <= i_prog_sel;
            if (prot_now)
            begin
              state_q    <= ST_WIPE;
              o_mem_wipe <= 1'b1;
            end
            else
            begin
              state_q <= ST_ERASE;
              cnt_q   <= ERASE_CYC[7:0];
            end
          end
        end
        ST_WIPE:
        begin
          if (i_mem_wipe_done)
          begin
            o_mem_wipe <= 1'b0;
            state_q    <= ST_ERASE;
            cnt_q      <= ERASE_CYC[7:0];
          end
        end
        ST_ERASE:
        begin
          if (cnt_q == 8'h00)
            state_q <= ST_IDLE;
          else
            cnt_q <= cnt_q - 8'h01;
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // Store is not reset: it models non-volatile content
  initial
  begin
    nv0_q = `OBCD_SHIP_BYTE0;
    nv1_q = `OBCD_SHIP_BYTE1;
  end

  always @(posedge i_core_clk)
  begin
    if (state_q == ST_ERASE && cnt_q == 8'h00)
    begin
      if (sel_q)
        nv1_q <= `OBCD_ERASED;
      else
        nv0_q <= `OBCD_ERASED;
    end
    else if (port_ok && i_prog_cmd == `OBCD_CMD_WRITE)
    begin
      if (i_prog_sel)
        nv1_q <= nv1_q & i_prog_wdata;
      else
        nv0_q <= nv0_q & i_prog_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Capture during reset, hold until next reset

  reg rst_seen_q;
  always @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      rst_seen_q <= 1'b0;
    else
      rst_seen_q <= 1'b1;
  end

  always @(posedge i_core_clk)
  begin
    if (!rst_seen_q)
    begin
      cfg0_q <= src0;
      cfg1_q <= src1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Decoded settings

  function [12:0] rst_len;
    input sel;
    begin
      rst_len = sel ? `OBCD_RST_CYC_SHORT : `OBCD_RST_CYC_LONG;
    end
  endfunction

  assign o_dog_enable_by_software  = cfg0_q[`OBCD_B0_DOG_SW_BIT];
  assign o_dog_hw_enable           = ~cfg0_q[`OBCD_B0_DOG_SW_BIT];
  assign o_halt_triggers_dog_reset = cfg0_q[`OBCD_B0_HALT_RST_BIT];

  always @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_halt_reset <= 1'b0;
    else
      o_halt_reset <= i_halt_enter & cfg0_q[`OBCD_B0_HALT_RST_BIT] &
                      (i_dog_active | o_dog_hw_enable);
  end

  assign o_readout_protect_n = cfg0_q[`OBCD_B0_RDPROT_N_BIT];
  assign o_block_readout     = ~cfg0_q[`OBCD_B0_RDPROT_N_BIT];
  assign o_block_flash_write = ~cfg0_q[`OBCD_B0_RDPROT_N_BIT];

  assign o_package_select = cfg1_q[`OBCD_B1_PKG_BIT];

  // Unbonded pads: upper four of the last two ports on
  // small packages; the pad logic holds them input pull-up
  genvar g;
  generate
    for (g = 0; g < NUM_PORTS*8; g = g + 1)
    begin : g_pad
      if (g >= (NUM_PORTS-2)*8 && (g % 8) >= 4)
        assign o_pad_unbonded[g] = ~cfg1_q[`OBCD_B1_PKG_BIT];
      else
        assign o_pad_unbonded[g] = 1'b0;
    end
  endgenerate

  assign o_reset_phase_length_sel = cfg1_q[`OBCD_B1_RSTLEN_BIT];
  assign o_reset_cycles = rst_len(cfg1_q[`OBCD_B1_RSTLEN_BIT]);

  assign o_clock_source_type =
    cfg1_q[`OBCD_B1_OSC_HI_BIT:`OBCD_B1_OSC_LO_BIT];
  assign o_clk_resonator = (o_clock_source_type == `OBCD_OSC_RESONATOR);
  assign o_clk_reserved  = (o_clock_source_type == `OBCD_OSC_RESERVED);
  assign o_clk_int_rc    = (o_clock_source_type == `OBCD_OSC_INT_RC);
  assign o_clk_external  = (o_clock_source_type == `OBCD_OSC_EXTERNAL);

endmodule // obcd_decoder

// ---- obcd_regs.vh ----
// Purpose: Constants for the configuration byte decoder
// Assumes: Two 8-bit configuration bytes, erased value 8'hFF
// Notes:   Field positions, defaults, encodings and cycle counts
`ifndef OBCD_REGS_VH
`define OBCD_REGS_VH

// Byte 0 fields
`define OBCD_B0_HALT_RST_BIT    7
`define OBCD_B0_DOG_SW_BIT      6
`define OBCD_B0_RDPROT_N_BIT    0
`define OBCD_B0_RSVD_MASK       8'h3E
// Byte 1 fields
`define OBCD_B1_PKG_BIT         7
`define OBCD_B1_RSTLEN_BIT      6
`define OBCD_B1_OSC_HI_BIT      5
`define OBCD_B1_OSC_LO_BIT      4
`define OBCD_B1_RSVD_MASK       8'h0F

// Erased content and shipped defaults
`define OBCD_ERASED             8'hFF
`define OBCD_SHIP_BYTE0         8'hE7
`define OBCD_SHIP_BYTE1         8'hEF

// Clock source encodings
`define OBCD_OSC_RESONATOR      2'h0
`define OBCD_OSC_RESERVED       2'h1
`define OBCD_OSC_INT_RC         2'h2
`define OBCD_OSC_EXTERNAL       2'h3

// Reset phase lengths in CPU cycles
`define OBCD_RST_CYC_LONG       13'h1000
`define OBCD_RST_CYC_SHORT      13'h0100

// RC oscillator nominal rates in kHz
`define OBCD_RC_OSC_KHZ         3500
`define OBCD_RC_CPU_KHZ         1750

// Programming port commands
`define OBCD_CMD_WRITE          2'h1
`define OBCD_CMD_ERASE          2'h2

`endif

// ---- obcd_wipe_model.sv ----
// Purpose: Memory side answering user memory wipe requests
// Assumes: Delay set by the bench, zero answers promptly
// Notes:   Done stays high until the request drops
`timescale 1ns/100ps
module obcd_wipe_model
(
  input  wire       i_core_clk,
  input  wire       i_mem_wipe,
  input  wire [3:0] i_delay,
  output reg        o_done
);
  reg [3:0] cnt_q;
  initial
  begin
    cnt_q = 4'h0;
    o_done = 1'b0;
  end
  always @(posedge i_core_clk)
  begin
    o_done <= 1'b0;
    if (!i_mem_wipe)
      cnt_q <= 4'h0;
    else if (cnt_q == i_delay)
      o_done <= 1'b1;
    else
      cnt_q <= cnt_q + 4'h1;
  end
endmodule // obcd_wipe_model

// ---- tb_option_byte_config_decoder.sv ----
// Purpose: Self-checking bench for the configuration byte decoder
// Assumes: Programming port driven on rising edges
// Notes:   Short erase count keeps the run brief
`timescale 1ns/100ps
`include "obcd_regs.vh"
module tb_option_byte_config_decoder;
  reg        clk, rst_n, mode, sel, rd, dog, halt;
  reg  [1:0] cmd;
  reg  [7:0] wd;
  reg  [3:0] dly;
  wire [7:0] rdata;
  wire [12:0] cyc;
  wire [1:0] osc;
  wire       busy, wipe, done, hrst, trig, sw, prn, blk, pkg;
  integer    num_errors = 0, samples_checked = 0, n;
  obcd_decoder #(.ERASE_CYC(2)) u_dut (.i_core_clk(clk), .i_rst_n(rst_n),
    .i_prog_mode(mode), .i_prog_cmd(cmd), .i_prog_sel(sel),
    .i_prog_wdata(wd), .i_prog_rd(rd), .o_prog_rdata(rdata),
    .o_prog_busy(busy), .o_mem_wipe(wipe), .i_mem_wipe_done(done),
    .i_dog_active(dog), .i_halt_enter(halt), .o_halt_reset(hrst),
    .o_halt_triggers_dog_reset(trig), .o_dog_enable_by_software(sw),
    .o_dog_hw_enable(), .o_readout_protect_n(prn), .o_block_readout(blk),
    .o_block_flash_write(), .o_package_select(pkg), .o_pad_unbonded(),
    .o_reset_phase_length_sel(), .o_reset_cycles(cyc),
    .o_clock_source_type(osc), .o_clk_resonator(), .o_clk_int_rc(),
    .o_clk_external(), .o_clk_reserved());
  obcd_wipe_model u_mem (.i_core_clk(clk), .i_mem_wipe(wipe),
    .i_delay(dly), .o_done(done));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////
  task check(input [15:0] seen, input [15:0] exp);
  begin
    samples_checked = samples_checked + 1;
    if (seen !== exp)
    begin
      num_errors = num_errors + 1;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  end
  endtask
  task do_reset;
  begin
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  end
  endtask
  task prog(input [1:0] c, input s, input [7:0] d);
  begin
    @(posedge clk);
    cmd <= c; sel <= s; wd <= d;
    @(posedge clk);
    cmd <= 2'h0;
    #1;
  end
  endtask
  task rdb(input s, input [7:0] exp);
  begin
    @(posedge clk);
    rd <= 1'b1; sel <= s;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(rdata, exp);
  end
  endtask
  task settings(input [7:0] e);
    check({trig, sw, prn, blk, pkg, cyc == 13'h0100, osc}, e);
  endtask
  task erase(input s);
  begin
    prog(2'h2, s, 8'h00);
    for (n = 0; n < 40 && busy === 1'b1; n = n + 1) @(posedge clk);
    check(busy, 1'b0);
    rdb(s, `OBCD_ERASED);
  end
  endtask
  task t_defaults;
  begin
    settings(8'hEE);
    rdb(0, 8'h00);
    mode <= 1'b1;
    rdb(0, `OBCD_SHIP_BYTE0);
    rdb(1, `OBCD_SHIP_BYTE1);
  end
  endtask
  task t_program;
  begin
    prog(2'h1, 1'b1, 8'h0F);
    prog(2'h1, 1'b0, 8'h26);
    rdb(0, 8'h26);
    settings(8'hEE);
    do_reset;
    settings(8'h10);
    @(posedge clk) dog <= 1'b1; halt <= 1'b1;
    @(posedge clk) halt <= 1'b0;
    #1 check(hrst, 1'b0);
  end
  endtask
  task t_erase;
  begin
    dly <= 4'h5;
    prog(2'h2, 1'b0, 8'h00);
    check(wipe, 1'b1);
    for (n = 0; n < 40 && busy === 1'b1; n = n + 1) @(posedge clk);
    rdb(0, `OBCD_ERASED);
    erase(1'b1);
    do_reset;
    settings(8'hEF);
    @(posedge clk) halt <= 1'b1;
    @(posedge clk) halt <= 1'b0;
    #1 check(hrst, 1'b1);
  end
  endtask
  task final_report;
  begin
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask
  ////////////////////////////////////////////////////////////////////
  initial
  begin
    mode = 1'b0; sel = 1'b0; rd = 1'b0; dog = 1'b0; halt = 1'b0;
    cmd = 2'h0; wd = 8'h00; dly = 4'h0; rst_n = 1'b0;
    do_reset;
    t_defaults;
    t_program;
    t_erase;
    final_report;
  end
  // Whole run is about fifty cycles
  initial
  begin
    #20000;
    num_errors = num_errors + 1;
    final_report;
  end
endmodule // tb_option_byte_config_decoder
